//--- trig_seq_pkg.sv
// Constants, types and the register map of the measurement trigger sequencer.
package trig_seq_pkg;
	// Clock rate and derived timing.
	localparam int CLK_MHZ = 10;
	localparam int DLY_STEP_US = 100;
	localparam int STEP_CYC = DLY_STEP_US * CLK_MHZ;
	localparam int DONE_PULSE_US = 2;
	localparam int DONE_CYC = DONE_PULSE_US * CLK_MHZ;
	// Count and delay limits.
	localparam int CNT_W = 16;
	localparam int DLY_W = 26;
	localparam logic [15:0] LOCAL_CNT_MAX = 16'h07D0;
	localparam logic [15:0] DISPLAY_CNT_MAX = 16'h270F;
	localparam logic [25:0] DLY_MAX = 26'h2255100;
	localparam logic [15:0] CNT_RESET = 16'h0001;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SAMP = 8'h04;
	localparam logic [7:0] OFS_TRIG = 8'h08;
	localparam logic [7:0] OFS_DELAY = 8'h0C;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_SAMP_LOC = 8'h18;
	localparam logic [7:0] OFS_TRIG_LOC = 8'h1C;
	// Control fields and their values after reset.
	localparam int CTRL_REMOTE = 0;
	localparam int CTRL_SRC_LO = 1;
	localparam int CTRL_AUTO_DLY = 3;
	localparam int CTRL_LOCAL_EXT = 4;
	localparam logic [4:0] CTRL_RESET = 5'h08;
	// Command fields.
	localparam int CMD_INIT = 0;
	localparam int CMD_TRG = 1;
	localparam int CMD_ABORT = 2;
	// Remote trigger sources.
	localparam logic [1:0] SRC_IMM = 2'h0;
	localparam logic [1:0] SRC_BUS = 2'h1;
	localparam logic [1:0] SRC_EXT = 2'h2;
	// Measurement function codes seen by the automatic delay.
	localparam logic [2:0] FN_DC = 3'h0;
	localparam logic [2:0] FN_AC = 3'h1;
	localparam logic [2:0] FN_RES = 3'h2;
	localparam logic [2:0] FN_FREQ = 3'h3;
	localparam logic [2:0] FN_CAP = 3'h4;
	// Automatic delay figures in microseconds.
	localparam int AD_DC_SLOW_US = 1500;
	localparam int AD_DC_FAST_US = 1000;
	localparam int AD_AC_R3_US = 7000000;
	localparam int AD_AC_R20_US = 1000000;
	localparam int AD_AC_R200_US = 600000;
	localparam int AD_AC_L3_US = 1500000;
	localparam int AD_AC_L20_US = 200000;
	localparam int AD_AC_L200_US = 100000;
	localparam int AD_RS_LO_US = 1500;
	localparam int AD_RS_MID_US = 15000;
	localparam int AD_RF_LO_US = 1000;
	localparam int AD_RF_MID_US = 10000;
	localparam int AD_R_HI_US = 100000;
	localparam int AD_FREQ_US = 1000000;
	// Sequencer states.
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_DELAY, ST_MEAS, ST_DONE} seq_state_t;
	// Measurement setup that selects the automatic delay.
	typedef struct packed {
		logic [2:0] func;
		logic plc_ge1;
		logic [1:0] range;
		logic [1:0] filter;
	} auto_cfg_t;
endpackage : trig_seq_pkg

//--- measurement_trigger_sequencer.sv
// Trigger sequencer: idle, wait-for-event, settling delay, measurement and completion pulse.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
// What this block does
// - Measure only after leaving idle and then triggering in wait-for-event.
// - Each accepted trigger yields exactly the programmed sample count of measurements.
// - Accept trigger count events, then idle; total is triggers times samples.
// - After a group, wait for next trigger if any remain, else idle.
// - Immediate source triggers internally on entering wait-for-event.
// - Immediate source exists only remotely and is the remote default.
// - Bus trigger command gives one trigger event with bus source.
// - Initiate command moves the sequencer from idle into wait-for-event.
// - External source takes front key press or outside pulse as trigger.
// - Emit a low-true completion pulse after every single measurement.
// - Sample count goes up to 2000 by local entry and up to 65535 remotely, volatile, one after power-up.
// - Trigger count goes up to 2000 by local entry and up to 65535 remotely, volatile, one after power-up.
// - Trigger count is ignored locally and only applies remotely.
// - Local entry caps counts at 2000; above 9999 shows overload.
// - Wait the trigger delay before each measurement so input settles.
// - Manual delay spans 0 to 3600 s in 100 us steps.
// - Automatic delay after power-up; manual delay is volatile.
// - Automatic delay follows function, range, integration time and filter.
// - Automatic delay values per function as in the delay table.
// - Local auto triggering measures continuously from power-up.
module measurement_trigger_sequencer #(
	parameter int CNT_W = trig_seq_pkg::CNT_W
) (
	// Clock, reset and clock enable.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Register port.
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Measurement setup and handshake with the converter.
	input wire trig_seq_pkg::auto_cfg_t auto_cfg_i,
	input wire logic meas_done_i,
	output logic meas_start_o,
	// Pins.
	input wire logic outside_trigger_input_n_i,
	input wire logic trigger_key_n_i,
	output logic measure_done_pulse_n_o,
	// Front status.
	output logic ready_o,
	output logic samp_overload_indication_o,
	output logic trig_overload_indication_o
);
	if (CNT_W < 14 || CNT_W > 32) begin : g_bad_cnt_w
		$error("CNT_W must lie between 14 and 32");
	end

	// Converts a delay in microseconds to delay steps.
	function automatic logic [25:0] us2st(input int us);
		us2st = 26'(us / trig_seq_pkg::DLY_STEP_US);
	endfunction : us2st

	// Automatic delay in steps for the given setup and trigger mode.
	function automatic logic [25:0] auto_steps(input trig_seq_pkg::auto_cfg_t c, input logic rem);
		logic [25:0] v;
		v = 26'h0000000;
		case (c.func)
			trig_seq_pkg::FN_DC: v = us2st(c.plc_ge1 ? trig_seq_pkg::AD_DC_SLOW_US :
				trig_seq_pkg::AD_DC_FAST_US);
			trig_seq_pkg::FN_AC: begin
				if (c.filter == 2'h0) begin
					v = us2st(rem ? trig_seq_pkg::AD_AC_R3_US : trig_seq_pkg::AD_AC_L3_US);
				end else if (c.filter == 2'h1) begin
					v = us2st(rem ? trig_seq_pkg::AD_AC_R20_US : trig_seq_pkg::AD_AC_L20_US);
				end else begin
					v = us2st(rem ? trig_seq_pkg::AD_AC_R200_US : trig_seq_pkg::AD_AC_L200_US);
				end
			end
			trig_seq_pkg::FN_RES: begin
				if (c.range == 2'h0) begin
					v = us2st(c.plc_ge1 ? trig_seq_pkg::AD_RS_LO_US : trig_seq_pkg::AD_RF_LO_US);
				end else if (c.range == 2'h1) begin
					v = us2st(c.plc_ge1 ? trig_seq_pkg::AD_RS_MID_US : trig_seq_pkg::AD_RF_MID_US);
				end else begin
					v = us2st(trig_seq_pkg::AD_R_HI_US);
				end
			end
			trig_seq_pkg::FN_FREQ: v = rem ? us2st(trig_seq_pkg::AD_FREQ_US) : 26'h0000000;
			default: v = 26'h0000000;
		endcase
		auto_steps = v;
	endfunction : auto_steps

	// Clamps a written count to at least one and to an optional ceiling.
	function automatic logic [CNT_W-1:0] clamp_cnt(input logic [31:0] w, input logic cap);
		logic [CNT_W-1:0] v;
		v = w[CNT_W-1:0];
		if (w[CNT_W-1:0] == '0) begin
			v = CNT_W'(trig_seq_pkg::CNT_RESET);
		end
		if (cap && w > 32'(trig_seq_pkg::LOCAL_CNT_MAX)) begin
			v = CNT_W'(trig_seq_pkg::LOCAL_CNT_MAX);
		end
		clamp_cnt = v;
	endfunction : clamp_cnt

	logic [4:0] ctrl_ff;
	logic [CNT_W-1:0] samp_cnt_ff;
	logic [CNT_W-1:0] trigger_events_item_ff;
	logic [25:0] dly_ff;
	trig_seq_pkg::seq_state_t state_ff;
	logic [CNT_W-1:0] samp_left_ff;
	logic [CNT_W-1:0] trig_left_ff;
	logic [25:0] dly_left_ff;
	logic [9:0] pre_ff;
	logic [4:0] pulse_ff;
	logic [2:0] ext_sync_ff;
	logic [2:0] key_sync_ff;
	logic meas_start_ff;
	logic done_n_ff;
	logic [31:0] rdata_ff;
	logic ready_ff;
	logic samp_ovl_ff;
	logic trig_ovl_ff;

	// Register decode and command strobes.
	wire wr_ctrl = reg_wr_i && reg_addr_i == trig_seq_pkg::OFS_CTRL;
	wire wr_samp = reg_wr_i && reg_addr_i == trig_seq_pkg::OFS_SAMP;
	wire wr_trig = reg_wr_i && reg_addr_i == trig_seq_pkg::OFS_TRIG;
	wire wr_samp_loc = reg_wr_i && reg_addr_i == trig_seq_pkg::OFS_SAMP_LOC;
	wire wr_trig_loc = reg_wr_i && reg_addr_i == trig_seq_pkg::OFS_TRIG_LOC;
	wire wr_dly = reg_wr_i && reg_addr_i == trig_seq_pkg::OFS_DELAY;
	wire wr_cmd = reg_wr_i && reg_addr_i == trig_seq_pkg::OFS_CMD;
	wire cmd_init = wr_cmd && reg_wdata_i[trig_seq_pkg::CMD_INIT];
	wire cmd_trg = wr_cmd && reg_wdata_i[trig_seq_pkg::CMD_TRG];
	wire cmd_abort = wr_cmd && reg_wdata_i[trig_seq_pkg::CMD_ABORT];

	// Mode fields.
	wire remote = ctrl_ff[trig_seq_pkg::CTRL_REMOTE];
	wire [1:0] src = ctrl_ff[trig_seq_pkg::CTRL_SRC_LO +: 2];
	wire auto_dly = ctrl_ff[trig_seq_pkg::CTRL_AUTO_DLY];
	wire local_ext = ctrl_ff[trig_seq_pkg::CTRL_LOCAL_EXT];

	// Falling edges of the synchronised outside input and front key.
	wire ext_edge = ext_sync_ff[2] && !ext_sync_ff[1];
	wire key_edge = key_sync_ff[2] && !key_sync_ff[1];
	wire ext_event = ext_edge || key_edge;

	// Trigger selection; immediate exists only under remote control.
	wire remote_trig = (src == trig_seq_pkg::SRC_IMM) ||
		(src == trig_seq_pkg::SRC_BUS && cmd_trg) ||
		(src == trig_seq_pkg::SRC_EXT && ext_event);
	wire local_trig = local_ext ? ext_event : 1'b1;
	wire trig_now = remote ? remote_trig : local_trig;

	// Delay to apply before each sample.
	wire [25:0] dly_steps = auto_dly ? auto_steps(auto_cfg_i, remote) : dly_ff;
	wire step_end = pre_ff == 10'(trig_seq_pkg::STEP_CYC - 1);
	wire pulse_end = pulse_ff == 5'(trig_seq_pkg::DONE_CYC - 1);
	wire more_samp = samp_left_ff > CNT_W'(1);
	wire more_trig = !remote || trig_left_ff > CNT_W'(1);

	// Read multiplexer; unmapped offsets read zero.
	wire [31:0] status_word = {24'h000000, 1'b0, samp_ovl_ff, trig_ovl_ff, 2'h0, state_ff};
	wire [31:0] rd_mux =
		(reg_addr_i == trig_seq_pkg::OFS_CTRL) ? {27'h0000000, ctrl_ff} :
		(reg_addr_i == trig_seq_pkg::OFS_SAMP) ? 32'(samp_cnt_ff) :
		(reg_addr_i == trig_seq_pkg::OFS_TRIG) ? 32'(trigger_events_item_ff) :
		(reg_addr_i == trig_seq_pkg::OFS_DELAY) ? {6'h00, dly_ff} :
		(reg_addr_i == trig_seq_pkg::OFS_STATUS) ? status_word : 32'h00000000;

	// Settings registers, volatile with fixed power-up values.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_ff <= trig_seq_pkg::CTRL_RESET;
			samp_cnt_ff <= CNT_W'(trig_seq_pkg::CNT_RESET);
			trigger_events_item_ff <= CNT_W'(trig_seq_pkg::CNT_RESET);
			dly_ff <= 26'h0000000;
		end else if (ce_i) begin
			if (wr_ctrl) begin
				ctrl_ff <= reg_wdata_i[4:0];
			end
			if (wr_samp || wr_samp_loc) begin
				samp_cnt_ff <= clamp_cnt(reg_wdata_i, wr_samp_loc);
			end
			if (wr_trig || wr_trig_loc) begin
				trigger_events_item_ff <= clamp_cnt(reg_wdata_i, wr_trig_loc);
			end
			if (wr_dly) begin
				dly_ff <= (reg_wdata_i > 32'(trig_seq_pkg::DLY_MAX)) ? trig_seq_pkg::DLY_MAX :
					reg_wdata_i[25:0];
			end
		end
	end

	// Pin synchronisers and edge history.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ext_sync_ff <= 3'h7;
			key_sync_ff <= 3'h7;
		end else if (ce_i) begin
			ext_sync_ff <= {ext_sync_ff[1:0], outside_trigger_input_n_i};
			key_sync_ff <= {key_sync_ff[1:0], trigger_key_n_i};
		end
	end

	// Sequencer state machine.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_ff <= trig_seq_pkg::ST_IDLE;
			samp_left_ff <= '0;
			trig_left_ff <= '0;
			dly_left_ff <= 26'h0000000;
			pre_ff <= 10'h000;
			pulse_ff <= 5'h00;
			meas_start_ff <= 1'b0;
			done_n_ff <= 1'b1;
		end else if (ce_i) begin
			meas_start_ff <= 1'b0;
			if (cmd_abort) begin
				state_ff <= trig_seq_pkg::ST_IDLE;
				done_n_ff <= 1'b1;
			end else begin
				case (state_ff)
					trig_seq_pkg::ST_IDLE: begin
						if (cmd_init || !remote) begin
							state_ff <= trig_seq_pkg::ST_WAIT;
							trig_left_ff <= trigger_events_item_ff;
						end
					end
					trig_seq_pkg::ST_WAIT: begin
						if (trig_now) begin
							state_ff <= trig_seq_pkg::ST_DELAY;
							samp_left_ff <= samp_cnt_ff;
							dly_left_ff <= dly_steps;
							pre_ff <= 10'h000;
						end
					end
					trig_seq_pkg::ST_DELAY: begin
						if (dly_left_ff == 26'h0000000) begin
							state_ff <= trig_seq_pkg::ST_MEAS;
							meas_start_ff <= 1'b1;
						end else if (step_end) begin
							pre_ff <= 10'h000;
							dly_left_ff <= dly_left_ff - 26'h0000001;
						end else begin
							pre_ff <= pre_ff + 10'h001;
						end
					end
					trig_seq_pkg::ST_MEAS: begin
						if (meas_done_i) begin
							state_ff <= trig_seq_pkg::ST_DONE;
							done_n_ff <= 1'b0;
							pulse_ff <= 5'h00;
						end
					end
					trig_seq_pkg::ST_DONE: begin
						if (!pulse_end) begin
							pulse_ff <= pulse_ff + 5'h01;
						end else begin
							done_n_ff <= 1'b1;
							if (more_samp) begin
								state_ff <= trig_seq_pkg::ST_DELAY;
								samp_left_ff <= samp_left_ff - CNT_W'(1);
								dly_left_ff <= dly_steps;
								pre_ff <= 10'h000;
							end else if (more_trig) begin
								state_ff <= trig_seq_pkg::ST_WAIT;
								trig_left_ff <= trig_left_ff - CNT_W'(1);
							end else begin
								state_ff <= trig_seq_pkg::ST_IDLE;
							end
						end
					end
					default: state_ff <= trig_seq_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// Read data, ready indicator and overload display.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdata_ff <= 32'h00000000;
			ready_ff <= 1'b0;
			samp_ovl_ff <= 1'b0;
			trig_ovl_ff <= 1'b0;
		end else if (ce_i) begin
			rdata_ff <= reg_rd_i ? rd_mux : 32'h00000000;
			ready_ff <= state_ff == trig_seq_pkg::ST_WAIT;
			samp_ovl_ff <= 32'(samp_cnt_ff) > 32'(trig_seq_pkg::DISPLAY_CNT_MAX);
			trig_ovl_ff <= 32'(trigger_events_item_ff) > 32'(trig_seq_pkg::DISPLAY_CNT_MAX);
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign meas_start_o = meas_start_ff;
	assign measure_done_pulse_n_o = done_n_ff;
	assign ready_o = ready_ff;
	assign samp_overload_indication_o = samp_ovl_ff;
	assign trig_overload_indication_o = trig_ovl_ff;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// A measurement start is only ever issued out of the delay state.
	property p_start_from_delay;
		$rose(meas_start_o) |-> $past(state_ff) == trig_seq_pkg::ST_DELAY;
	endproperty
	a_start_from_delay: assert property (p_start_from_delay)
		else $error("measurement started outside the delay state");

	// A pending sample goes back to the delay state.
	property p_next_sample;
		(ce_i && !cmd_abort && state_ff == trig_seq_pkg::ST_DONE && pulse_end && more_samp)
			|=> state_ff == trig_seq_pkg::ST_DELAY && measure_done_pulse_n_o == 1'b1;
	endproperty
	a_next_sample: assert property (p_next_sample)
		else $error("sample group ended early");

	// The last remote group returns to idle.
	property p_last_group;
		(ce_i && !cmd_abort && state_ff == trig_seq_pkg::ST_DONE && pulse_end && !more_samp &&
			remote && trig_left_ff == CNT_W'(1)) |=> state_ff == trig_seq_pkg::ST_IDLE;
	endproperty
	a_last_group: assert property (p_last_group)
		else $error("no return to idle after the last trigger");

	// Remaining triggers lead back to wait-for-event.
	property p_more_groups;
		(ce_i && !cmd_abort && state_ff == trig_seq_pkg::ST_DONE && pulse_end && !more_samp &&
			more_trig) |=> state_ff == trig_seq_pkg::ST_WAIT;
	endproperty
	a_more_groups: assert property (p_more_groups)
		else $error("no wait for the next trigger");

	// Immediate source leaves wait-for-event at once.
	property p_immediate;
		(ce_i && !cmd_abort && remote && src == trig_seq_pkg::SRC_IMM &&
			state_ff == trig_seq_pkg::ST_WAIT) |=> state_ff == trig_seq_pkg::ST_DELAY;
	endproperty
	a_immediate: assert property (p_immediate)
		else $error("immediate trigger not taken");

	// Initiate moves idle to wait-for-event.
	property p_initiate;
		(ce_i && cmd_init && !cmd_abort && state_ff == trig_seq_pkg::ST_IDLE)
			|=> state_ff == trig_seq_pkg::ST_WAIT ##1 ready_o || !ce_i;
	endproperty
	a_initiate: assert property (p_initiate)
		else $error("initiate ignored in idle");

	// The completion pulse stays low for at least the first 8 cycles after the measurement ends.
	property p_done_pulse;
		(ce_i && !cmd_abort && state_ff == trig_seq_pkg::ST_MEAS && meas_done_i)
			|=> !measure_done_pulse_n_o [*8];
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("completion pulse missing or too short");

	// Counts and delay mode take their power-up values.
	property p_power_up;
		!$past(rst_n_i) |-> samp_cnt_ff == CNT_W'(1) && trigger_events_item_ff == CNT_W'(1) && auto_dly;
	endproperty
	a_power_up: assert property (p_power_up)
		else $error("wrong settings after reset");

	// Local entry never stores more than the local ceiling.
	property p_local_cap;
		(ce_i && (wr_samp_loc || wr_trig_loc)) |=>
			(!$past(wr_samp_loc) || 32'(samp_cnt_ff) <= 32'(trig_seq_pkg::LOCAL_CNT_MAX)) &&
			(!$past(wr_trig_loc) || 32'(trigger_events_item_ff) <= 32'(trig_seq_pkg::LOCAL_CNT_MAX));
	endproperty
	a_local_cap: assert property (p_local_cap)
		else $error("local count above ceiling");

	// A measurement in progress is not disturbed by triggers.
	property p_no_queue;
		(ce_i && !cmd_abort && state_ff == trig_seq_pkg::ST_MEAS && !meas_done_i)
			|=> state_ff == trig_seq_pkg::ST_MEAS;
	endproperty
	a_no_queue: assert property (p_no_queue)
		else $error("trigger disturbed a measurement");
endmodule : measurement_trigger_sequencer

//--- switch_system_model.sv
// Behavioural switch system that steps through channels and triggers the sequencer by pin.
`timescale 1ns/10ps
module switch_system_model #(
	parameter int SETTLE = 5
) (
	// Clock.
	input wire logic clk_sys_i,
	// Run control from the bench.
	input wire logic run_i,
	input wire logic [7:0] chan_total_i,
	output logic [7:0] chan_done_o,
	// Pins.
	input wire logic measure_done_pulse_n_i,
	output logic outside_trigger_input_n_o
);
	int guard;
	// The trigger line has a pull-up, so it idles high; this one process owns both outputs.
	// It closes a channel, pulses low, and advances once the completion pulse has ended or after 5000 cycles of waiting.
	initial begin
		outside_trigger_input_n_o = 1'b1;
		chan_done_o = 8'h00;
		forever begin
			@(posedge clk_sys_i);
			if (run_i) begin
				chan_done_o <= 8'h00;
				for (int ch = 0; ch < chan_total_i; ch++) begin
					repeat (SETTLE) @(posedge clk_sys_i);
					outside_trigger_input_n_o <= 1'b0;
					repeat (4) @(posedge clk_sys_i);
					outside_trigger_input_n_o <= 1'b1;
					guard = 0;
					while (measure_done_pulse_n_i && guard < 5000) begin
						@(posedge clk_sys_i);
						guard++;
					end
					while (!measure_done_pulse_n_i && guard < 5000) begin
						@(posedge clk_sys_i);
						guard++;
					end
					chan_done_o <= 8'(ch + 1);
				end
				while (run_i) @(posedge clk_sys_i);
			end
		end
	end
endmodule : switch_system_model

//--- measurement_trigger_sequencer_tb_top.sv
// Self-checking testbench of the measurement trigger sequencer.
`timescale 1ns/10ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module measurement_trigger_sequencer_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic meas_done = 1'b0;
	logic meas_start;
	logic outside_trigger_input_n;
	logic key_n = 1'b1;
	logic measure_done_pulse_n;
	logic ready;
	logic samp_ovl;
	logic trig_ovl;
	logic ce = 1'b1;
	logic run = 1'b0;
	logic [7:0] chan_done;
	logic [2:0] cv_sr = 3'h0;
	logic done_q = 1'b1;
	int cyc = 0;
	int starts = 0;
	int dones = 0;
	int start_cyc = 0;
	int n_mismatch = 0;
	int compares = 0;
	// The capacitance setup has zero automatic delay, which keeps local runs short.
	trig_seq_pkg::auto_cfg_t auto_cfg = '{func: trig_seq_pkg::FN_CAP, default: '0};
	measurement_trigger_sequencer u_measurement_trigger_sequencer (
		.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(ce),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .auto_cfg_i(auto_cfg),
		.meas_done_i(meas_done), .meas_start_o(meas_start),
		.outside_trigger_input_n_i(outside_trigger_input_n), .trigger_key_n_i(key_n),
		.measure_done_pulse_n_o(measure_done_pulse_n), .ready_o(ready),
		.samp_overload_indication_o(samp_ovl), .trig_overload_indication_o(trig_ovl)
	);
	switch_system_model u_switch_system_model (
		.clk_sys_i(clk), .run_i(run), .chan_total_i(8'h03), .chan_done_o(chan_done),
		.measure_done_pulse_n_i(measure_done_pulse_n),
		.outside_trigger_input_n_o(outside_trigger_input_n)
	);
	always #50 clk = ~clk;
	// Converter answers four cycles after each start; starts and pulses are counted.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		cv_sr <= {cv_sr[1:0], meas_start};
		meas_done <= cv_sr[2];
		done_q <= measure_done_pulse_n;
		if (meas_start === 1'b1) begin
			starts <= starts + 1;
			start_cyc <= cyc;
		end
		if (done_q === 1'b1 && measure_done_pulse_n === 1'b0) begin
			dones <= dones + 1;
		end
	end
	// One write cycle on the register port.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// One read cycle; data is taken in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		`CHK(what, exp, d)
	endtask : chk_rd
	// Polls the status state field until it matches, with a bounded count.
	task automatic wait_state(input logic [2:0] st);
		logic [31:0] d;
		int n;
		n = 0;
		d = 32'h000000FF;
		while (d[2:0] !== st && n < 3000) begin
			rd(trig_seq_pkg::OFS_STATUS, d);
			n++;
		end
		`CHK("state", st, d[2:0])
	endtask : wait_state
	task automatic test_end(input string name);
		$display("test %s done", name);
	endtask : test_end
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	// Watchdog against a hung sequence.
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		close_out();
	end
	// Main test sequence.
	initial begin
		int s0;
		int d0;
		int n;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (300) @(posedge clk);
		`CHK("local run", 1'b1, starts >= 3)
		chk_rd("ctrl", trig_seq_pkg::OFS_CTRL, 32'h8);
		chk_rd("samp", trig_seq_pkg::OFS_SAMP, 32'h1);
		chk_rd("trig", trig_seq_pkg::OFS_TRIG, 32'h1);
		chk_rd("delay", trig_seq_pkg::OFS_DELAY, 32'h0);
		chk_rd("cmd", trig_seq_pkg::OFS_CMD, 32'h0);
		chk_rd("unmapped", 8'h40, 32'h0);
		test_end("reset");
		wr(trig_seq_pkg::OFS_SAMP_LOC, 32'h00000BB8);
		chk_rd("samp local", trig_seq_pkg::OFS_SAMP, 32'h000007D0);
		wr(trig_seq_pkg::OFS_TRIG_LOC, 32'h00001388);
		chk_rd("trig local", trig_seq_pkg::OFS_TRIG, 32'h000007D0);
		wr(trig_seq_pkg::OFS_SAMP, 32'h00002710);
		wr(trig_seq_pkg::OFS_TRIG, 32'h00002710);
		repeat (2) @(posedge clk);
		`CHK("samp ovl", 1'b1, samp_ovl)
		`CHK("trig ovl", 1'b1, trig_ovl)
		chk_rd("samp remote", trig_seq_pkg::OFS_SAMP, 32'h00002710);
		wr(trig_seq_pkg::OFS_SAMP, 32'h0);
		chk_rd("samp zero", trig_seq_pkg::OFS_SAMP, 32'h1);
		`CHK("samp ovl off", 1'b0, samp_ovl)
		@(posedge clk);
		ce <= 1'b0;
		wr(trig_seq_pkg::OFS_SAMP, 32'h5);
		ce <= 1'b1;
		chk_rd("ce hold", trig_seq_pkg::OFS_SAMP, 32'h1);
		wr(trig_seq_pkg::OFS_DELAY, 32'h03FFFFFF);
		chk_rd("delay max", trig_seq_pkg::OFS_DELAY, {6'h00, trig_seq_pkg::DLY_MAX});
		test_end("counts");
		wr(trig_seq_pkg::OFS_CTRL, 32'h3);
		wr(trig_seq_pkg::OFS_DELAY, 32'h0);
		wr(trig_seq_pkg::OFS_CMD, 32'h4);
		wait_state(trig_seq_pkg::ST_IDLE);
		wr(trig_seq_pkg::OFS_SAMP, 32'h3);
		wr(trig_seq_pkg::OFS_TRIG, 32'h2);
		s0 = starts;
		d0 = dones;
		wr(trig_seq_pkg::OFS_CMD, 32'h2);
		repeat (50) @(posedge clk);
		`CHK("idle trigger", 0, starts - s0)
		wr(trig_seq_pkg::OFS_CMD, 32'h1);
		wait_state(trig_seq_pkg::ST_WAIT);
		wr(trig_seq_pkg::OFS_CMD, 32'h2);
		wr(trig_seq_pkg::OFS_CMD, 32'h2);
		wait_state(trig_seq_pkg::ST_WAIT);
		`CHK("group starts", 3, starts - s0)
		`CHK("group pulses", 3, dones - d0)
		wr(trig_seq_pkg::OFS_CMD, 32'h2);
		wait_state(trig_seq_pkg::ST_IDLE);
		`CHK("total starts", 6, starts - s0)
		`CHK("total pulses", 6, dones - d0)
		test_end("bus");
		wr(trig_seq_pkg::OFS_CTRL, 32'h1);
		wr(trig_seq_pkg::OFS_SAMP, 32'h2);
		s0 = starts;
		wr(trig_seq_pkg::OFS_CMD, 32'h1);
		wait_state(trig_seq_pkg::ST_IDLE);
		`CHK("immediate starts", 4, starts - s0)
		test_end("immediate");
		wr(trig_seq_pkg::OFS_CTRL, 32'h5);
		wr(trig_seq_pkg::OFS_TRIG, 32'h4);
		wr(trig_seq_pkg::OFS_SAMP, 32'h1);
		s0 = starts;
		wr(trig_seq_pkg::OFS_CMD, 32'h1);
		wait_state(trig_seq_pkg::ST_WAIT);
		wr(trig_seq_pkg::OFS_CMD, 32'h2);
		repeat (20) @(posedge clk);
		`CHK("bus trigger ext", 0, starts - s0)
		run <= 1'b1;
		n = 0;
		while (chan_done !== 8'h03 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		run <= 1'b0;
		wait_state(trig_seq_pkg::ST_WAIT);
		`CHK("ready", 1'b1, ready)
		`CHK("pin starts", 3, starts - s0)
		@(posedge clk);
		key_n <= 1'b0;
		repeat (4) @(posedge clk);
		key_n <= 1'b1;
		wait_state(trig_seq_pkg::ST_IDLE);
		`CHK("key starts", 4, starts - s0)
		wr(trig_seq_pkg::OFS_CTRL, 32'h10);
		s0 = starts;
		repeat (40) @(posedge clk);
		key_n <= 1'b0;
		repeat (4) @(posedge clk);
		key_n <= 1'b1;
		repeat (60) @(posedge clk);
		`CHK("local key", 1, starts - s0)
		test_end("external");
		wr(trig_seq_pkg::OFS_CTRL, 32'h3);
		wr(trig_seq_pkg::OFS_CMD, 32'h4);
		wr(trig_seq_pkg::OFS_DELAY, 32'h1);
		wr(trig_seq_pkg::OFS_TRIG, 32'h1);
		wr(trig_seq_pkg::OFS_CMD, 32'h1);
		wait_state(trig_seq_pkg::ST_WAIT);
		wr(trig_seq_pkg::OFS_CMD, 32'h2);
		s0 = cyc;
		wait_state(trig_seq_pkg::ST_IDLE);
		`CHK("delay gap", 1'b1, start_cyc - s0 >= 1000 && start_cyc - s0 <= 1010)
		test_end("delay");
		wr(trig_seq_pkg::OFS_CTRL, 32'hB);
		auto_cfg <= '{func: trig_seq_pkg::FN_DC, default: '0};
		wr(trig_seq_pkg::OFS_CMD, 32'h1);
		wait_state(trig_seq_pkg::ST_WAIT);
		wr(trig_seq_pkg::OFS_CMD, 32'h2);
		s0 = cyc;
		repeat (10020) @(posedge clk);
		`CHK("auto gap", 1'b1, start_cyc - s0 >= 10000 && start_cyc - s0 <= 10010)
		wait_state(trig_seq_pkg::ST_IDLE);
		test_end("auto delay");
		close_out();
	end
endmodule : measurement_trigger_sequencer_tb_top
